// ===== hw/lam_pkg.sv
/*
 * lam_pkg: register map, field positions, reset values and detector counts
 * for the line alarm status monitor.
 * Assumes: every file of the block imports the whole package.
 */
package lam_pkg;
    // ----------------------------------------------------------------
    // channel count and data widths
    // ----------------------------------------------------------------
    localparam int NCH = 12;
    localparam int AMP_W = 8;
    localparam int FILL_W = 6;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_LO_STATUS = 4'h3;  // channel alarm status at 0xm3
    localparam logic [3:0] IDX_LO_CTRL = 4'h0;    // channel control at 0xm0
    localparam logic [7:0] IDX_CFG = 8'hf0;
    localparam logic [7:0] IDX_IRQ_ST = 8'hf1;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf2;

    // ----------------------------------------------------------------
    // alarm status bits; 0, 6 and 7 read as zero
    // ----------------------------------------------------------------
    localparam int ST_LOS = 1;
    localparam int ST_LOL = 2;
    localparam int ST_FL = 3;
    localparam int ST_ALOS = 4;
    localparam int ST_DLOS = 5;

    // ----------------------------------------------------------------
    // channel control and global configuration fields
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_DS3 = 2'h0;
    localparam logic [1:0] MODE_E3 = 2'h1;
    localparam logic [1:0] MODE_STS1 = 2'h2;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_JA_EN = 2;
    localparam int CTRL_JA_DEEP = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int CFG_DECL_LSB = 0;
    localparam int CFG_CLR_LSB = 8;
    localparam int CFG_SYNTH = 16;
    localparam logic [16:0] CFG_RESET = 17'h03020;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // detector counts, in bit periods, reference periods or FIFO entries
    // ----------------------------------------------------------------
    localparam int DLOS_ZERO_RUN = 160;
    localparam int DENS_WIN = 32;
    localparam int DENS_PCT = 33;
    localparam int DENS_MIN = (DENS_PCT * DENS_WIN + 99) / 100;
    localparam int LOL_WIN = 2000;
    localparam int LOL_PPM = 5000;
    localparam int LOL_TOL = LOL_WIN * LOL_PPM / 1000000;
    localparam int FL_MARGIN = 2;
    localparam int DEPTH_SHALLOW = 16;
    localparam int DEPTH_DEEP = 32;
endpackage

// ===== hw/lam_chan_if.sv
/*
 * lam_chan_if: per-channel signals between the register top and one channel.
 * Assumes: all signals are on CLK.
 */
`timescale 1ns/10ps
interface lam_chan_if;
    import lam_pkg::*;
    logic line_tick;
    logic line_pulse;
    logic ref_tick;
    logic g775_los;
    logic [AMP_W-1:0] amp;
    logic [AMP_W-1:0] decl_th;
    logic [AMP_W-1:0] clr_th;
    logic [FILL_W-1:0] fill;
    logic [1:0] mode;
    logic ja_en;
    logic ja_deep;
    logic dlos;
    logic alos;
    logic los;
    logic clock_lock_loss;
    logic fl;
    modport mon (input line_tick, line_pulse, ref_tick, g775_los, amp, decl_th, clr_th,
        fill, mode, ja_en, ja_deep, output dlos, alos, los, clock_lock_loss, fl);
    modport host (output line_tick, line_pulse, ref_tick, g775_los, amp, decl_th, clr_th,
        fill, mode, ja_en, ja_deep, input dlos, alos, los, clock_lock_loss, fl);
endinterface

// ===== hw/lam_chan.sv
/*
 * lam_chan: alarm detectors of one channel (digital and analog loss of
 * signal, FIFO limit, loss of lock).
 * Assumes: tick and pulse inputs are one-cycle enables made on CLK.
 */
`timescale 1ns/10ps
module lam_chan
    import lam_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    lam_chan_if.mon ch
);
    logic [7:0] zero_run;
    logic [4:0] win_cnt;
    logic [5:0] ones;
    logic [10:0] ref_cnt;
    logic [11:0] rec_cnt;
    logic dlos;
    logic alos;
    logic clock_lock_loss;
    logic fl;

    // ----------------------------------------------------------------
    // detector decisions
    // ----------------------------------------------------------------
    wire ds3like = ch.mode != MODE_E3;
    wire zero_done = ch.line_tick && !ch.line_pulse && zero_run == 8'(DLOS_ZERO_RUN - 1);
    wire [5:0] ones_next = ones + 6'(ch.line_pulse);
    wire win_last = ch.line_tick && win_cnt == 5'(DENS_WIN - 1);
    wire dens_ok = win_last && ones_next >= 6'(DENS_MIN);
    wire next_dlos = ds3like && (zero_done || (dlos && !dens_ok));
    // hysteresis: once declared, only amplitude above the upper level or E3 mode clears
    wire next_alos = ds3like && (ch.amp < ch.decl_th || (alos && ch.amp <= ch.clr_th));
    wire win_end = ch.ref_tick && ref_cnt == 11'(LOL_WIN - 1);
    wire [11:0] rec_now = rec_cnt + 12'(ch.line_tick);
    wire [11:0] dev = rec_now > 12'(LOL_WIN) ? rec_now - 12'(LOL_WIN) : 12'(LOL_WIN) - rec_now;
    wire off_freq = dev >= 12'(LOL_TOL);
    wire [5:0] depth = ch.ja_deep ? 6'(DEPTH_DEEP) : 6'(DEPTH_SHALLOW);
    wire near_edge = ch.fill <= 6'(FL_MARGIN) || ch.fill >= depth - 6'(FL_MARGIN);

    // ----------------------------------------------------------------
    // detector state
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            zero_run <= 8'h00;
            win_cnt <= 5'h00;
            ones <= 6'h00;
            ref_cnt <= 11'h000;
            rec_cnt <= 12'h000;
            dlos <= 1'b0;
            alos <= 1'b0;
            clock_lock_loss <= 1'b0;
            fl <= 1'b0;
        end
        else
        begin
            if (ch.line_tick)
            begin
                // saturating run length, so a long silence never wraps
                zero_run <= ch.line_pulse ? 8'h00 :
                    (zero_run < 8'(DLOS_ZERO_RUN) ? zero_run + 8'h01 : zero_run);
                win_cnt <= win_cnt + 5'h01;
                ones <= win_last ? 6'h00 : ones_next;
            end
            if (ch.ref_tick)
                ref_cnt <= win_end ? 11'h000 : ref_cnt + 11'h001;
            // hold at full scale rather than wrap; a full count must never read as empty
            rec_cnt <= win_end ? 12'h000 : (rec_cnt == 12'hfff ? rec_cnt : rec_now);
            dlos <= next_dlos;
            alos <= next_alos;
            clock_lock_loss <= win_end ? off_freq : clock_lock_loss;
            fl <= ch.ja_en && near_edge;
        end
    end

    // ----------------------------------------------------------------
    // outputs; in E3 the combined state follows the G.775 detector
    // ----------------------------------------------------------------
    assign ch.dlos = dlos;
    assign ch.alos = alos;
    assign ch.clock_lock_loss = clock_lock_loss;
    assign ch.fl = fl;
    assign ch.los = ds3like ? (dlos || alos) : ch.g775_los;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_dlos_set;
        @(posedge clk) disable iff (!nrst) (ds3like && zero_done) |=> dlos;
    endproperty
    a_dlos_set: assert property (p_dlos_set) else $error("dlos not set after zero run");
    property p_dlos_clr;
        @(posedge clk) disable iff (!nrst) (dlos && dens_ok && !zero_done) |=> !dlos;
    endproperty
    a_dlos_clr: assert property (p_dlos_clr) else $error("dlos not cleared by density");
    property p_alos_decl;
        @(posedge clk) disable iff (!nrst) (ds3like && ch.amp < ch.decl_th) |=> alos;
    endproperty
    a_alos_decl: assert property (p_alos_decl) else $error("alos not declared");
    property p_alos_hyst;
        @(posedge clk) disable iff (!nrst)
            (alos && ds3like && ch.amp <= ch.clr_th) |=> alos;
    endproperty
    a_alos_hyst: assert property (p_alos_hyst) else $error("alos cleared below clr level");
    property p_los_or;
        @(posedge clk) disable iff (!nrst) ($rose(dlos) && ds3like) |-> ch.los;
    endproperty
    a_los_or: assert property (p_los_or) else $error("los misses dlos");
    property p_los_e3;
        @(posedge clk) disable iff (!nrst) (!ds3like) |-> (ch.los == ch.g775_los) ##1 !dlos;
    endproperty
    a_los_e3: assert property (p_los_e3) else $error("e3 los not from g775");
    property p_fl_off;
        @(posedge clk) disable iff (!nrst) (!ch.ja_en) |=> !fl;
    endproperty
    a_fl_off: assert property (p_fl_off) else $error("fl set while ja disabled");
    property p_fl_edge;
        @(posedge clk) disable iff (!nrst) ##1 (fl == $past(ch.ja_en && near_edge));
    endproperty
    a_fl_edge: assert property (p_fl_edge) else $error("fl wrong for fill");
    property p_lol;
        @(posedge clk) disable iff (!nrst) win_end |=> (clock_lock_loss == $past(off_freq));
    endproperty
    a_lol: assert property (p_lol) else $error("lol not updated at window end");
    c_dlos: cover property (@(posedge clk) disable iff (!nrst) $rose(dlos));
    c_dlos_clr: cover property (@(posedge clk) disable iff (!nrst) $fell(dlos));
    c_lol: cover property (@(posedge clk) disable iff (!nrst) $rose(clock_lock_loss));
    c_fl: cover property (@(posedge clk) disable iff (!nrst) $rose(fl));
endmodule // lam_chan

// ===== hw/lam_top.sv
/*
 * lam_top: twelve-channel line alarm status monitor with an AXI4-Lite
 * register slave, per-channel control and a level interrupt.
 * Assumes: line ticks, pulses, reference ticks, amplitude and fill words
 * come from on-chip receive logic on CLK; one write and one read at a time.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - in DS3 and STS-1 the digital detector declares after 160 bit periods with no pulse.
// - in DS3 and STS-1 the digital detector clears once pulse density reaches 33 percent.
// - status bit 5 is the read-only digital detector state.
// - in DS3 and STS-1 the analog detector declares when amplitude drops below its lower level.
// - in DS3 and STS-1 the analog detector clears only above a higher level and shows at read-only bit 4.
// - in DS3 and STS-1 channel loss of signal is the OR of the analog and digital detectors.
// - the combined loss of signal reads at bit 1 of the status register.
// - the FIFO limit alarm at bit 3 rises when fill is within two of overflow or underrun.
// - the FIFO limit alarm falls as soon as fill leaves that margin.
// - the FIFO limit alarm stays low while the jitter attenuator is disabled.
// - loss of lock is declared when the recovered rate is 0.5 percent or more off reference.
// - status bit 2 is the read-only loss of lock state.
// - channels 0 to 11 each have their own status register at index 0xm3.
// - in E3 the combined loss of signal follows the G.775 detector.
module lam_top
    import lam_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [NCH-1:0] LINE_TICK,
    input wire logic [NCH-1:0] LINE_PULSE,
    input wire logic [NCH-1:0] REF_OSC_TICK,
    input wire logic SYNTH_TICK,
    input wire logic [NCH-1:0] G775_LOS,
    input wire logic [NCH*AMP_W-1:0] AMP,
    input wire logic [NCH*FILL_W-1:0] FIFO_FILL,
    output logic IRQ
);
    // ----------------------------------------------------------------
    // channel index helper: m = 0..5 -> ch 0..5, m = 8..13 -> ch 6..11
    // ----------------------------------------------------------------
    function automatic logic [4:0] m_to_ch(input logic [3:0] m);
        logic [4:0] r;
        r = 5'h00;
        if (m < 4'h6)
            r = {1'b1, m};
        else if (m >= 4'h8 && m <= 4'hd)
            r = {1'b1, m - 4'h2};
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0] ctrl [NCH];
    logic [16:0] cfg;
    logic [2*NCH-1:0] irq_st;
    logic [2*NCH-1:0] irq_mask;
    logic [NCH-1:0] los_prev;
    logic [NCH-1:0] lol_prev;
    logic [NCH-1:0] los_v;
    logic [NCH-1:0] lol_v;
    logic [7:0] st_word [NCH];
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire [7:0] wr_idx = S_AXI_AWADDR[9:2];
    wire [7:0] rd_idx = S_AXI_ARADDR[9:2];
    wire [4:0] wr_chv = m_to_ch(wr_idx[7:4]);
    wire [4:0] rd_chv = m_to_ch(rd_idx[7:4]);
    wire [3:0] wr_ch = wr_chv[3:0];
    wire [3:0] rd_ch = rd_chv[3:0];
    wire wr_hs = S_AXI_AWVALID && S_AXI_WVALID && !bvalid;
    wire wr_ctrl = wr_chv[4] && wr_idx[3:0] == IDX_LO_CTRL;
    wire wr_st = wr_chv[4] && wr_idx[3:0] == IDX_LO_STATUS;
    wire wr_cfg = wr_idx == IDX_CFG;
    wire wr_ist = wr_idx == IDX_IRQ_ST;
    wire wr_imask = wr_idx == IDX_IRQ_MASK;
    wire wr_ok = wr_ctrl || wr_st || wr_cfg || wr_ist || wr_imask;
    wire rd_hs = S_AXI_ARVALID && !rvalid;
    wire rd_ctrl = rd_chv[4] && rd_idx[3:0] == IDX_LO_CTRL;
    wire rd_st = rd_chv[4] && rd_idx[3:0] == IDX_LO_STATUS;
    wire rd_ok = rd_ctrl || rd_st || rd_idx == IDX_CFG || rd_idx == IDX_IRQ_ST ||
        rd_idx == IDX_IRQ_MASK;
    wire [31:0] bmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
        {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
    wire [31:0] wbits = S_AXI_WDATA & bmask;

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    lam_chan_if chif [NCH] ();

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gch
            // the synthesizer tick replaces every oscillator tick in single reference mode
            assign chif[g].line_tick = LINE_TICK[g];
            assign chif[g].line_pulse = LINE_PULSE[g];
            assign chif[g].ref_tick = cfg[CFG_SYNTH] ? SYNTH_TICK : REF_OSC_TICK[g];
            assign chif[g].g775_los = G775_LOS[g];
            assign chif[g].amp = AMP[g*AMP_W +: AMP_W];
            assign chif[g].decl_th = cfg[CFG_DECL_LSB +: AMP_W];
            assign chif[g].clr_th = cfg[CFG_CLR_LSB +: AMP_W];
            assign chif[g].fill = FIFO_FILL[g*FILL_W +: FILL_W];
            assign chif[g].mode = ctrl[g][CTRL_MODE_LSB +: 2];
            assign chif[g].ja_en = ctrl[g][CTRL_JA_EN];
            assign chif[g].ja_deep = ctrl[g][CTRL_JA_DEEP];

            lam_chan u_chan (
                .clk(CLK),
                .nrst(NRST),
                .ch(chif[g])
            );

            // live status word, nothing latched
            assign st_word[g] = {2'h0, chif[g].dlos, chif[g].alos, chif[g].fl,
                chif[g].clock_lock_loss, chif[g].los, 1'b0};
            assign los_v[g] = chif[g].los;
            assign lol_v[g] = chif[g].clock_lock_loss;

            property p_rd_status;
                @(posedge CLK) disable iff (!NRST)
                    (S_AXI_ARVALID && S_AXI_ARREADY && rd_st && rd_ch == 4'(g))
                    |=> (S_AXI_RDATA[ST_DLOS] == $past(chif[g].dlos))
                    && (S_AXI_RDATA[ST_LOS] == $past(chif[g].los))
                    && (S_AXI_RDATA[ST_LOL] == $past(chif[g].clock_lock_loss)) && S_AXI_RVALID;
            endproperty
            a_rd_status: assert property (p_rd_status) else $error("status read mismatch");
        end
    endgenerate

    // ----------------------------------------------------------------
    // read selection
    // ----------------------------------------------------------------
    wire [31:0] rd_word =
        rd_st ? {24'h000000, st_word[rd_ch]} :
        rd_ctrl ? {28'h0000000, ctrl[rd_ch]} :
        rd_idx == IDX_CFG ? {15'h0000, cfg} :
        rd_idx == IDX_IRQ_ST ? {8'h00, irq_st} :
        rd_idx == IDX_IRQ_MASK ? {8'h00, irq_mask} : 32'h00000000;

    // ----------------------------------------------------------------
    // events: rising loss of signal and rising loss of lock
    // ----------------------------------------------------------------
    wire [2*NCH-1:0] ev = {lol_v & ~lol_prev, los_v & ~los_prev};
    wire [2*NCH-1:0] ist_clr = (wr_hs && wr_ist) ? wbits[2*NCH-1:0] : '0;
    // a new event beats a write-one-to-clear in the same cycle
    wire [2*NCH-1:0] next_irq_st = (irq_st & ~ist_clr) | ev;

    // ----------------------------------------------------------------
    // control registers; status writes fall through untouched
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!NRST)
                ctrl[i] <= CTRL_RESET;
            else if (wr_hs && wr_ctrl && wr_ch == 4'(i))
                ctrl[i] <= (ctrl[i] & ~bmask[3:0]) | wbits[3:0];
        end
    end

    // global configuration and interrupt registers
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            cfg <= CFG_RESET;
            irq_st <= '0;
            irq_mask <= '0;
            los_prev <= '0;
            lol_prev <= '0;
        end
        else
        begin
            if (wr_hs && wr_cfg)
                cfg <= (cfg & ~bmask[16:0]) | wbits[16:0];
            if (wr_hs && wr_imask)
                irq_mask <= (irq_mask & ~bmask[2*NCH-1:0]) | wbits[2*NCH-1:0];
            irq_st <= next_irq_st;
            los_prev <= los_v;
            lol_prev <= lol_v;
        end
    end

    // ----------------------------------------------------------------
    // write response: one cycle after address and data are taken together
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_hs)
        begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
            bvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // read response: data registered one cycle after the address
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end
        else if (rd_hs)
        begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RREADY)
            rvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // address and data are only taken together, which keeps a single write path
    assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !bvalid;
    assign S_AXI_WREADY = S_AXI_AWVALID && S_AXI_WVALID && !bvalid;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;
    assign IRQ = |(irq_st & irq_mask);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_st_write_ignored;
        @(posedge CLK) disable iff (!NRST)
            (wr_hs && wr_st) |=> (S_AXI_BRESP == RESP_OKAY) && S_AXI_BVALID
            && $stable(cfg) && $stable(irq_mask);
    endproperty
    a_st_write_ignored: assert property (p_st_write_ignored) else $error("status write had effect");
    property p_map_hole;
        @(posedge CLK) disable iff (!NRST)
            (rd_hs && rd_idx[3:0] == IDX_LO_STATUS && !rd_chv[4])
            |=> S_AXI_RRESP == RESP_SLVERR;
    endproperty
    a_map_hole: assert property (p_map_hole) else $error("hole in channel map answered");
    property p_irq_sticky;
        @(posedge CLK) disable iff (!NRST) (ev[0]) |=> irq_st[0];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("los event lost");
    c_wr: cover property (@(posedge CLK) disable iff (!NRST) wr_hs && wr_ctrl);
    c_rd_st: cover property (@(posedge CLK) disable iff (!NRST) rd_hs && rd_st);
    c_irq: cover property (@(posedge CLK) disable iff (!NRST) $rose(IRQ));
endmodule // lam_top

// ===== tb/lam_line_model.sv
/*
 * lam_line_model: recovered line source, one bit tick per cycle while run is high.
 * Assumes: clk is the block clock and the bench drives run and pon on it.
 */
`timescale 1ns/10ps
module lam_line_model
(
    input wire logic clk,
    input wire logic [11:0] run,
    input wire logic [11:0] pon,
    output logic [11:0] tick,
    output logic [11:0] pulse
);
    initial
    begin
        tick = 12'h000;
        pulse = 12'h000;
    end
    // pulse means nothing outside a tick, so it flips there rather than holding
    always @(posedge clk)
    begin
        tick <= run;
        pulse <= (run & pon) | (~run & ~pulse);
    end
endmodule // lam_line_model

// ===== tb/line_alarm_status_monitor_bench.sv
/*
 * line_alarm_status_monitor_bench: self-checking bench of the alarm monitor.
 * Assumes: lam_pkg, lam_top and lam_line_model are compiled first.
 */
`timescale 1ns/10ps
module line_alarm_status_monitor_bench;
    import lam_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic CLK = 0, NRST = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic awr, wr, arr, bv, rv, irq;
    logic [1:0] bresp, rresp, rsp, refm = 2'h0;
    logic [11:0] aw = 0, ar = 0, run = 0, pon = 0, refo = 0, g775 = 0, tick, pls;
    logic [31:0] wd = 0, rdata, rd_d;
    logic [95:0] amp = {12{8'h80}};
    logic [71:0] fill = 0;
    logic [3:0] cw, ae = 4'b0110;
    logic [7:0] av[4] = '{8'h20, 8'h1f, 8'h30, 8'h31};
    int fc[6] = '{2, 3, 29, 30, 14, 13};
    int failures = 0, tests_run = 0, seed = 66, cyc = 0, n, f, k;
    always #4 CLK = ~CLK;
    // the cycle ceiling cuts a hang short; the reference tick of channel 5 runs here
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        refo[5] <= (refm == 2'h1) | ((refm == 2'h2) & ~refo[5]);
        if (cyc == 20000)
        begin
            failures++;
            final_report();
        end
    end
    lam_top DUT (.CLK(CLK), .NRST(NRST), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .LINE_TICK(tick),
        .LINE_PULSE(pls), .REF_OSC_TICK(refo), .SYNTH_TICK(refm[0]), .G775_LOS(g775),
        .AMP(amp), .FIFO_FILL(fill), .IRQ(irq));
    lam_line_model LINE (.clk(CLK), .run(run), .pon(pon), .tick(tick), .pulse(pls));
    // ----------------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------------
    task final_report;
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // one bus transfer; every handshake is judged on what the rising edge samples
    task bus(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        if (w)
        begin
            aw <= a;
            wd <= d;
            awv <= 1;
            wv <= 1;
        end
        else
        begin
            ar <= a;
            arv <= 1;
        end
        @(posedge CLK);
        while (!(w ? awr && wr : arr))
            @(posedge CLK);
        {awv, wv, arv} <= 3'h0;
        bry <= w;
        rry <= !w;
        @(posedge CLK);
        while (!(w ? bv : rv))
            @(posedge CLK);
        rsp = w ? bresp : rresp;
        rd_d = rdata;
        bry <= 0;
        rry <= 0;
    endtask
    function logic [11:0] ca(input int c, input logic [3:0] i);
        logic [3:0] m;
        m = (c < 6) ? c[3:0] : c[3:0] + 4'h2;
        return {2'h0, m, i, 2'h0};
    endfunction
    function logic [11:0] ga(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    function logic [31:0] es(input bit dl, al, fl, ll, g);
        logic [31:0] e;
        e = 32'h0;
        e[ST_DLOS] = dl;
        e[ST_ALOS] = al;
        e[ST_FL] = fl;
        e[ST_LOL] = ll;
        e[ST_LOS] = dl | al | g;
        return e;
    endfunction
    function bit flx(input bit ja, dp, input int v);
        return ja && (v <= FL_MARGIN || v >= (dp ? DEPTH_DEEP : DEPTH_SHALLOW) - FL_MARGIN);
    endfunction
    task rs(input int c, input logic [31:0] e);
        bus(0, ca(c, IDX_LO_STATUS), 32'h0);
        chk("status", e, rd_d);
    endtask
    task tk(input int c, input bit p, input int cnt);
        run[c] <= 1;
        pon[c] <= p;
        repeat (cnt) @(posedge CLK);
        run[c] <= 0;
        repeat (3) @(posedge CLK);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge CLK);
        NRST <= 1;
        rs(0, 0);
        bus(0, ga(8'h63), 32'h0);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        bus(1, ca(1, IDX_LO_STATUS), 32'hff);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        rs(1, 0);
        // corner fills first, then random settings on the upper channels
        for (k = 0; k < 16; k++)
        begin
            n = (k < 6) ? 0 : 6 + $unsigned($random(seed)) % 6;
            f = (k < 6) ? fc[k] : $unsigned($random(seed)) % 64;
            if (k < 6)
                cw = {k[1], 1'b1, 2'h0};
            else
                cw = 4'($random(seed));
            bus(1, ca(n, IDX_LO_CTRL), {28'h0, cw});
            fill[n*FILL_W +: FILL_W] <= f[5:0];
            repeat (3) @(posedge CLK);
            rs(n, es(0, 0, flx(cw[2], cw[3], f), 0, 0));
        end
        bus(1, ga(IDX_IRQ_MASK), 32'h4);
        tk(2, 0, 159);
        rs(2, 0);
        tk(2, 0, 1);
        rs(2, es(1, 0, 0, 0, 0));
        chk("irq", 32'h1, {31'h0, irq});
        bus(1, ga(IDX_IRQ_ST), 32'h4);
        chk("irq", 32'h0, {31'h0, irq});
        tk(2, 1, 64);
        rs(2, 0);
        for (k = 0; k < 4; k++)
        begin
            amp[3*AMP_W +: AMP_W] <= av[k];
            repeat (3) @(posedge CLK);
            rs(3, es(0, ae[k], 0, 0, 0));
        end
        bus(1, ca(4, IDX_LO_CTRL), {30'h0, MODE_E3});
        amp[4*AMP_W +: AMP_W] <= 8'h00;
        for (k = 0; k < 2; k++)
        begin
            g775[4] <= !k;
            repeat (3) @(posedge CLK);
            rs(4, es(0, 0, 0, 0, !k));
        end
        // line at twice the oscillator rate, then the synthesizer at the line rate
        run[5] <= 1;
        pon[5] <= 1;
        refm <= 2'h2;
        repeat (8200) @(posedge CLK);
        rs(5, es(0, 0, 0, 1, 0));
        bus(1, ga(IDX_CFG), {15'h0, CFG_RESET} | (32'h1 << CFG_SYNTH));
        refm <= 2'h3; // oscillator stops, so only the synthesizer can give lock
        repeat (4100) @(posedge CLK);
        rs(5, 0);
        final_report();
    end
endmodule // line_alarm_status_monitor_bench
